// File: rtl/msr_pkg.sv
// constants and types of the motor starter relay and protection control
// How it works
// - relay selector 0..4 or 10..14 runs the relay in timed mode
// - timed trigger: start cmd, start begins, bypass, stop cmd, shutdown done
// - nonzero delay counts whole seconds from trigger, relay changes on expiry
// - zero delay changes the relay at the trigger itself
// - changed state held until ready, then one more second, then restored
// - a new start command aborts timing and restarts the sequence
// - selector 5..9 or 15..19 mirrors fault, operating, ready, starting, bypass
// - state indication mode ignores the relay delay setting
// - fault indication only for fault codes 05, 06, 07, 08, 12, 15
// - operating means neither ready nor faulted
// - selector above 9 inverts the relay contact
// - soft stop time zero means free stop
// - start mode: 0 limit, 1 ramp, 2/3 kick, 4 current ramp, 5 dual
// - current limit applies only for start modes 0, 2 and 4
// - voltage ramp caps starting current at 400 percent
// - monitor mode opens fault contacts on overload or voltage fault
// - protection level decodes five levels 0 to 4
// - primary level keeps only overheat, short and input phase loss
// - overload trip times per level at three, four, five times current
// - advanced level is strict at start, standard timing otherwise
// - load ratio scales current thresholds to the motor
// - relay delay accepts 0..999 seconds, zero after reset
package msr_pkg;
	localparam logic [5:0] REG_RELAY = 6'h00;
	localparam logic [5:0] REG_START = 6'h01;
	localparam logic [5:0] REG_PROT  = 6'h02;
	localparam logic [5:0] REG_STAT  = 6'h03;
	localparam int unsigned SECOND_NS = 1000000000;
	localparam int unsigned CLK_NS    = 8;
	localparam int unsigned SEC_CYC   = SECOND_NS / CLK_NS;
	localparam int PRESC_W = 27;
	localparam logic [4:0] RST_SEL    = 5'h06;
	localparam logic [9:0] RST_DELAY  = 10'h000;
	localparam logic [9:0] MAX_DELAY  = 10'h3e7;
	localparam logic [7:0] RST_STOP   = 8'h02;
	localparam logic [7:0] MAX_STOP   = 8'h3c;
	localparam logic [2:0] RST_SMODE  = 3'h1;
	localparam logic [2:0] MAX_SMODE  = 3'h6;
	localparam logic [9:0] RST_CLIM   = 10'h118;
	localparam logic [9:0] MIN_CLIM   = 10'h032;
	localparam logic [9:0] MAX_CLIM   = 10'h1f4;
	localparam logic [9:0] VR_CAP     = 10'h190;
	localparam logic [7:0] RST_LRATIO = 8'h64;
	localparam logic [7:0] MIN_LRATIO = 8'h32;
	localparam logic [7:0] MAX_LRATIO = 8'hc8;
	localparam logic [2:0] RST_PLEVEL = 3'h2;
	localparam logic [2:0] MAX_PLEVEL = 3'h4;
	localparam logic [7:0] PE_PRIMARY = 8'h07;
	localparam logic [7:0] PE_ALL     = 8'hff;
	localparam logic [7:0] FLT_OVERLOAD = 8'h20;
	localparam logic [7:0] FLT_OVERVOLT = 8'h21;
	localparam logic [7:0] FLT_UNDRVOLT = 8'h22;
	typedef enum logic [1:0] {TM_IDLE, TM_COUNT, TM_HOLD, TM_READY} msr_tmr_t;
	typedef struct packed {
		logic start_cmd;
		logic start_begin;
		logic bypass_run;
		logic stop_cmd;
		logic shutdown_done;
	} msr_evt_t;
	typedef struct packed {
		logic       ready;
		logic       starting;
		logic       bypass;
		logic [7:0] fault_code;
		logic       overload;
		logic       over_volt;
		logic       under_volt;
	} msr_stat_t;
	typedef struct packed {
		logic       cur_limit;
		logic       volt_ramp;
		logic       kick_start;
		logic       cur_ramp;
		logic       dual_loop;
		logic       monitor;
		logic       limit_applies;
		logic       free_stop;
		logic [9:0] cur_cap;
		logic [9:0] cur_cap_scaled;
	} msr_start_t;
	typedef struct packed {
		logic [7:0] prot_en;
		logic       strict_start;
		logic [5:0] start_oc_s;
		logic [9:0] trip3_ds;
		logic [9:0] trip4_ds;
		logic [9:0] trip5_ds;
		logic [7:0] load_ratio;
	} msr_prot_t;
endpackage

// File: rtl/msr_ctrl.sv
// relay, start mode and protection level control with ahb-lite registers
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module msr_ctrl #(
	parameter int unsigned TICK_CYCLES = msr_pkg::SEC_CYC
) (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic [31:0]             hrdata,
	output logic                    hresp,
	// starter events and state
	input  wire msr_pkg::msr_evt_t  evt,
	input  wire msr_pkg::msr_stat_t stat,
	// outputs
	output logic                    relay_out,
	output logic                    fault_contacts_open,
	output logic [7:0]              fault_display,
	output msr_pkg::msr_start_t     start_cfg,
	output msr_pkg::msr_prot_t      prot_cfg
);

	// ==========================================
	// state
	localparam int PRESC_W_L = msr_pkg::PRESC_W;
	localparam logic [PRESC_W_L-1:0] TICK_LAST = PRESC_W_L'(TICK_CYCLES - 1);

	typedef struct packed {
		logic                   ap_valid;
		logic                   ap_write;
		logic [5:0]             ap_addr;
		logic                   hready;
		logic                   hresp;
		logic [31:0]            hrdata;
		logic [4:0]             sel;
		logic [9:0]             delay;
		logic [7:0]             stop_time;
		logic [2:0]             smode;
		logic [9:0]             climit;
		logic [7:0]             lratio;
		logic [2:0]             plevel;
		msr_pkg::msr_tmr_t      tmr;
		logic [9:0]             secs;
		logic [PRESC_W_L-1:0]   presc;
		logic                   active;
		logic                   relay;
		logic                   flt_open;
		logic [7:0]             flt_code;
		msr_pkg::msr_start_t    start;
		msr_pkg::msr_prot_t     prot;
	} msr_state_t;

	msr_state_t s_r;
	msr_state_t s_nxt;

	// ==========================================
	// next state
	always_comb begin
		logic [4:0]             base;
		logic                   timed;
		logic                   invert;
		logic                   trig;
		logic                   tick;
		logic                   elec;
		logic                   ind;
		msr_pkg::msr_tmr_t      cur;
		logic [4:0]             w_sel;
		logic [9:0]             w_delay;
		logic [7:0]             w_stop;
		logic [2:0]             w_smode;
		logic [9:0]             w_clim;
		logic [7:0]             w_lratio;
		logic [2:0]             w_plevel;
		logic [17:0]            prod;
		base     = 5'h00;
		timed    = 1'b0;
		invert   = 1'b0;
		trig     = 1'b0;
		tick     = 1'b0;
		elec     = 1'b0;
		ind      = 1'b0;
		cur      = msr_pkg::TM_IDLE;
		w_sel    = hwdata[4:0];
		w_delay  = hwdata[25:16];
		w_stop   = hwdata[7:0];
		w_smode  = hwdata[10:8];
		w_clim   = hwdata[25:16];
		w_lratio = hwdata[15:8];
		w_plevel = hwdata[2:0];
		prod     = 18'h00000;
		s_nxt    = s_r;

		// register writes in the data phase
		s_nxt.hready = 1'b1;
		s_nxt.hresp  = 1'b0;
		if (s_r.ap_valid && s_r.ap_write) begin
			unique case (s_r.ap_addr)
				msr_pkg::REG_RELAY: begin
					if (w_sel <= 5'd19) begin
						s_nxt.sel = w_sel;
					end
					if (w_delay <= msr_pkg::MAX_DELAY) begin
						s_nxt.delay = w_delay;
					end
				end
				msr_pkg::REG_START: begin
					if (w_stop <= msr_pkg::MAX_STOP) begin
						s_nxt.stop_time = w_stop;
					end
					if (w_smode <= msr_pkg::MAX_SMODE) begin
						s_nxt.smode = w_smode;
					end
					if (w_clim >= msr_pkg::MIN_CLIM && w_clim <= msr_pkg::MAX_CLIM) begin
						s_nxt.climit = w_clim;
					end
				end
				msr_pkg::REG_PROT: begin
					if (w_plevel <= msr_pkg::MAX_PLEVEL) begin
						s_nxt.plevel = w_plevel;
					end
					if (w_lratio >= msr_pkg::MIN_LRATIO && w_lratio <= msr_pkg::MAX_LRATIO) begin
						s_nxt.lratio = w_lratio;
					end
				end
				default: begin
				end
			endcase
		end

		// mode of the relay selector
		base   = (s_nxt.sel >= 5'd10) ? s_nxt.sel - 5'd10 : s_nxt.sel;
		timed  = (base <= 5'd4);
		invert = (s_nxt.sel > 5'd9);

		unique case (base)
			5'd0: trig = evt.start_cmd;
			5'd1: trig = evt.start_begin;
			5'd2: trig = evt.bypass_run;
			5'd3: trig = evt.stop_cmd;
			5'd4: trig = evt.shutdown_done;
			default: trig = 1'b0;
		endcase

		tick = (s_r.presc == TICK_LAST);
		s_nxt.presc = tick ? '0 : s_r.presc + 1'b1;

		unique case (stat.fault_code)
			8'h05, 8'h06, 8'h07, 8'h08, 8'h12, 8'h15: elec = 1'b1;
			default: elec = 1'b0;
		endcase

		unique case (base)
			5'd5: ind = elec;
			5'd6: ind = !stat.ready && (stat.fault_code == 8'h00);
			5'd7: ind = stat.ready;
			5'd8: ind = stat.starting;
			5'd9: ind = stat.bypass;
			default: ind = 1'b0;
		endcase

		if (!timed) begin
			s_nxt.tmr    = msr_pkg::TM_IDLE;
			s_nxt.secs   = 10'h000;
			s_nxt.active = ind;
		end else begin
			cur = evt.start_cmd ? msr_pkg::TM_IDLE : s_r.tmr;
			if (evt.start_cmd) begin
				s_nxt.active = 1'b0;
				s_nxt.secs   = 10'h000;
			end
			s_nxt.tmr = cur;
			unique case (cur)
				msr_pkg::TM_IDLE: begin
					if (trig) begin
						s_nxt.presc = '0;
						if (s_nxt.delay == 10'h000) begin
							s_nxt.active = 1'b1;
							s_nxt.tmr    = msr_pkg::TM_HOLD;
						end else begin
							s_nxt.secs = s_nxt.delay;
							s_nxt.tmr  = msr_pkg::TM_COUNT;
						end
					end
				end
				msr_pkg::TM_COUNT: begin
					if (tick) begin
						if (s_r.secs == 10'h001) begin
							s_nxt.secs   = 10'h000;
							s_nxt.active = 1'b1;
							s_nxt.tmr    = msr_pkg::TM_HOLD;
						end else begin
							s_nxt.secs = s_r.secs - 10'h001;
						end
					end
				end
				msr_pkg::TM_HOLD: begin
					if (stat.ready) begin
						s_nxt.presc = '0;
						s_nxt.tmr   = msr_pkg::TM_READY;
					end
				end
				msr_pkg::TM_READY: begin
					if (!stat.ready) begin
						s_nxt.tmr = msr_pkg::TM_HOLD;
					end else if (tick) begin
						s_nxt.active = 1'b0;
						s_nxt.tmr    = msr_pkg::TM_IDLE;
					end
				end
			endcase
		end
		s_nxt.relay = s_nxt.active ^ invert;

		if (evt.start_cmd) begin
			s_nxt.flt_open = 1'b0;
			s_nxt.flt_code = 8'h00;
		end
		if (s_nxt.smode == 3'd6) begin
			if (stat.overload) begin
				s_nxt.flt_open = 1'b1;
				s_nxt.flt_code = msr_pkg::FLT_OVERLOAD;
			end else if (stat.over_volt) begin
				s_nxt.flt_open = 1'b1;
				s_nxt.flt_code = msr_pkg::FLT_OVERVOLT;
			end else if (stat.under_volt) begin
				s_nxt.flt_open = 1'b1;
				s_nxt.flt_code = msr_pkg::FLT_UNDRVOLT;
			end
		end

		s_nxt.start.cur_limit  = (s_nxt.smode == 3'd0) || (s_nxt.smode == 3'd2);
		s_nxt.start.volt_ramp  = (s_nxt.smode == 3'd1) || (s_nxt.smode == 3'd3);
		s_nxt.start.kick_start = (s_nxt.smode == 3'd2) || (s_nxt.smode == 3'd3);
		s_nxt.start.cur_ramp   = (s_nxt.smode == 3'd4);
		s_nxt.start.dual_loop  = (s_nxt.smode == 3'd5);
		s_nxt.start.monitor    = (s_nxt.smode == 3'd6);
		s_nxt.start.limit_applies = (s_nxt.smode == 3'd0) || (s_nxt.smode == 3'd2)
			|| (s_nxt.smode == 3'd4);
		s_nxt.start.free_stop = (s_nxt.stop_time == 8'h00);
		if (s_nxt.start.limit_applies) begin
			s_nxt.start.cur_cap = s_nxt.climit;
		end else if (s_nxt.start.volt_ramp) begin
			s_nxt.start.cur_cap = msr_pkg::VR_CAP;
		end else begin
			s_nxt.start.cur_cap = 10'h000;
		end
		prod = s_nxt.start.cur_cap * s_nxt.lratio;
		s_nxt.start.cur_cap_scaled = 10'(prod / 18'd100);
		s_nxt.prot.load_ratio = s_nxt.lratio;

		s_nxt.prot.prot_en      = msr_pkg::PE_ALL;
		s_nxt.prot.strict_start = 1'b0;
		unique case (s_nxt.plevel)
			3'd0: begin
				s_nxt.prot.prot_en    = msr_pkg::PE_PRIMARY;
				s_nxt.prot.start_oc_s = 6'd0;
				s_nxt.prot.trip3_ds   = 10'd0;
				s_nxt.prot.trip4_ds   = 10'd0;
				s_nxt.prot.trip5_ds   = 10'd0;
			end
			3'd1: begin
				s_nxt.prot.start_oc_s = 6'd3;
				s_nxt.prot.trip3_ds   = 10'd45;
				s_nxt.prot.trip4_ds   = 10'd23;
				s_nxt.prot.trip5_ds   = 10'd15;
			end
			3'd3: begin
				s_nxt.prot.start_oc_s = 6'd30;
				s_nxt.prot.trip3_ds   = 10'd480;
				s_nxt.prot.trip4_ds   = 10'd230;
				s_nxt.prot.trip5_ds   = 10'd150;
			end
			default: begin
				s_nxt.prot.strict_start = (s_nxt.plevel == 3'd4);
				s_nxt.prot.start_oc_s   = 6'd15;
				s_nxt.prot.trip3_ds     = 10'd230;
				s_nxt.prot.trip4_ds     = 10'd120;
				s_nxt.prot.trip5_ds     = 10'd75;
			end
		endcase

		// address phase and read data
		s_nxt.ap_valid = hsel && hready && htrans[1];
		s_nxt.ap_write = hwrite;
		s_nxt.ap_addr  = haddr[7:2];
		if (hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h000000) begin
			unique case (haddr[7:2])
				msr_pkg::REG_RELAY: s_nxt.hrdata = {6'h00, s_nxt.delay, 11'h000, s_nxt.sel};
				msr_pkg::REG_START: s_nxt.hrdata = {6'h00, s_nxt.climit, 5'h00, s_nxt.smode,
					s_nxt.stop_time};
				msr_pkg::REG_PROT:  s_nxt.hrdata = {16'h0000, s_nxt.lratio, 5'h00, s_nxt.plevel};
				msr_pkg::REG_STAT:  s_nxt.hrdata = {6'h00, s_nxt.secs, s_nxt.flt_code, 3'h0,
					s_nxt.flt_open, s_nxt.tmr, s_nxt.active, s_nxt.relay};
				default: s_nxt.hrdata = 32'h00000000;
			endcase
		end else if (s_nxt.ap_valid) begin
			s_nxt.hrdata = 32'h00000000;
		end
		if (s_nxt.ap_valid && haddr[31:8] != 24'h000000) begin
			s_nxt.ap_addr = 6'h3f;
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r           <= '0;
			s_r.hready    <= 1'b1;
			s_r.sel       <= msr_pkg::RST_SEL;
			s_r.delay     <= msr_pkg::RST_DELAY;
			s_r.stop_time <= msr_pkg::RST_STOP;
			s_r.smode     <= msr_pkg::RST_SMODE;
			s_r.climit    <= msr_pkg::RST_CLIM;
			s_r.lratio    <= msr_pkg::RST_LRATIO;
			s_r.plevel    <= msr_pkg::RST_PLEVEL;
			s_r.tmr       <= msr_pkg::TM_IDLE;
			s_r.relay     <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// outputs
	assign hreadyout           = s_r.hready;
	assign hrdata              = s_r.hrdata;
	assign hresp               = s_r.hresp;
	assign relay_out           = s_r.relay;
	assign fault_contacts_open = s_r.flt_open;
	assign fault_display       = s_r.flt_code;
	assign start_cfg           = s_r.start;
	assign prot_cfg            = s_r.prot;

endmodule

// File: test/msr_ctrl_props.sv
// assertion checker for the relay and protection control
`timescale 1ns/1ps
module msr_chk (
	// clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// observed ports
	input wire msr_pkg::msr_stat_t  stat,
	input wire logic                relay_out,
	input wire logic                fault_contacts_open,
	input wire logic [7:0]          fault_display,
	input wire msr_pkg::msr_start_t start_cfg,
	input wire msr_pkg::msr_prot_t  prot_cfg
);
	// ========
	// properties
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_mon_trip: assert property (
		start_cfg.monitor && (stat.overload || stat.over_volt || stat.under_volt)
		|=> fault_contacts_open) else $error("monitor fault not latched");
	a_mon_code: assert property (
		$rose(fault_contacts_open) |-> fault_display inside {8'h20, 8'h21, 8'h22})
		else $error("bad monitor fault code");
	a_vr_cap: assert property (
		start_cfg.volt_ramp |-> start_cfg.cur_cap <= msr_pkg::VR_CAP)
		else $error("ramp current cap too high");
	a_lim_range: assert property (
		start_cfg.limit_applies |-> start_cfg.cur_cap >= msr_pkg::MIN_CLIM
		&& start_cfg.cur_cap <= msr_pkg::MAX_CLIM) else $error("current limit out of range");
	a_dual_nolim: assert property (
		start_cfg.dual_loop |-> !start_cfg.limit_applies) else $error("dual mode limit on");
	a_light_trip: assert property (
		prot_cfg.trip3_ds == 10'h02d |-> prot_cfg.trip4_ds == 10'h017
		&& prot_cfg.trip5_ds == 10'h00f) else $error("light trip times wrong");
	a_strict_std: assert property (
		prot_cfg.strict_start |-> prot_cfg.trip3_ds == 10'h0e6
		&& prot_cfg.trip4_ds == 10'h078 && prot_cfg.trip5_ds == 10'h04b)
		else $error("advanced trip times wrong");
	a_primary_off: assert property (
		prot_cfg.prot_en == msr_pkg::PE_PRIMARY |-> prot_cfg.trip3_ds == 10'h000
		&& !prot_cfg.strict_start) else $error("primary level not reduced");
	a_ratio_scale: assert property (
		32'(start_cfg.cur_cap) * 32'(prot_cfg.load_ratio) / 100
		== 32'(start_cfg.cur_cap_scaled)) else $error("scaled cap wrong");
	c_mon: cover property (fault_contacts_open);
	c_strict: cover property (prot_cfg.strict_start);
	c_relay: cover property ($rose(relay_out));
endmodule
bind msr_ctrl msr_chk u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.stat(stat),
	.relay_out(relay_out),
	.fault_contacts_open(fault_contacts_open),
	.fault_display(fault_display),
	.start_cfg(start_cfg),
	.prot_cfg(prot_cfg)
);

// File: test/testbench.sv
// self-checking testbench for the relay and protection control
`timescale 1ns/1ps
module testbench;
	localparam int TK = 20;
	logic                hclk;
	logic                hresetn;
	logic                hsel;
	logic                hwrite;
	logic                hreadyout;
	logic                hresp;
	logic                relay_out;
	logic                fco;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [7:0]          fdisp;
	logic [31:0]         haddr;
	logic [31:0]         hwdata;
	logic [31:0]         hrdata;
	logic [31:0]         q;
	msr_pkg::msr_evt_t   evt;
	msr_pkg::msr_stat_t  stat;
	msr_pkg::msr_start_t scfg;
	msr_pkg::msr_prot_t  pcfg;
	int                  err_total;
	int                  n_tests;
	int                  i;
	int                  j;
	logic [13:0] sv [6] = '{14'h2000, 14'h1000, 14'h0800, 14'h0090, 14'h2048, 14'h0028};
	logic [4:0]  ex [6] = '{5'h04, 5'h0a, 5'h09, 5'h10, 5'h04, 5'h10};
	logic [9:0]  t3 [5] = '{10'h000, 10'h02d, 10'h0e6, 10'h1e0, 10'h0e6};
	logic [9:0]  t5 [5] = '{10'h000, 10'h00f, 10'h04b, 10'h096, 10'h04b};
	logic [9:0]  t4 [5] = '{10'h000, 10'h017, 10'h078, 10'h0e6, 10'h078};
	logic [5:0]  oc [5] = '{6'h00, 6'h03, 6'h0f, 6'h1e, 6'h0f};
	msr_ctrl #(.TICK_CYCLES(TK)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .evt(evt), .stat(stat),
		.relay_out(relay_out), .fault_contacts_open(fco), .fault_display(fdisp),
		.start_cfg(scfg), .prot_cfg(pcfg));
	always #4 hclk = ~hclk;
	// ========
	// tasks
	task results;
		if (err_total == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			err_total++;
			results();
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task pulse(input logic [4:0] b);
		evt <= b;
		@(posedge hclk);
		evt <= 5'h00;
	endtask
	function automatic logic [31:0] rw(input int s, input int d);
		return {6'h00, 10'(d), 11'h000, 5'(s)};
	endfunction
	// ========
	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		evt = 5'h00;
		stat = 14'h2000;
		err_total = 0;
		n_tests = 0;
		cyc(5);
		chk("relay_in_reset", relay_out, 0);
		hresetn <= 1'b1;
		cyc(3);
		chk("relay_after_reset", relay_out, 0);
		bus(1'b0, 32'h0, 32'h0);
		chk("relay_reg", q, 32'h6);
		bus(1'b0, 32'h4, 32'h0);
		chk("start_reg", q, 32'h01180102);
		bus(1'b0, 32'h8, 32'h0);
		chk("prot_reg", q, 32'h6402);
		bus(1'b1, 32'h100, 32'h5);
		bus(1'b0, 32'h100, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, 32'h0, rw(6, 1000));
		bus(1'b0, 32'h0, 32'h0);
		chk("delay_max", q, 32'h6);
		for (i = 0; i < 10; i++) begin
			bus(1'b1, 32'h0, rw(i < 5 ? i + 5 : i + 10, 999));
			for (j = 0; j < 6; j++) begin
				stat <= sv[j];
				cyc(2);
				chk("relay_state", relay_out, 32'(ex[j][4 - i % 5] ^ (i >= 5)));
			end
		end
		for (i = 0; i < 10; i++) begin
			bus(1'b1, 32'h0, rw(i < 5 ? i : i + 5, 0));
			stat <= 14'h0000;
			cyc(2);
			chk("relay_idle", relay_out, 32'(i >= 5));
			pulse(5'h10 >> ((i + 1) % 5));
			cyc(2);
			chk("relay_other_evt", relay_out, 32'(i >= 5));
			pulse(5'h10 >> (i % 5));
			cyc(1);
			chk("relay_zero_delay", relay_out, 32'(i < 5));
			stat <= 14'h2000;
			cyc(TK - 4);
			chk("relay_hold", relay_out, 32'(i < 5));
			cyc(8);
			chk("relay_restore", relay_out, 32'(i >= 5));
		end
		bus(1'b1, 32'h0, rw(2, 2));
		pulse(5'h04);
		cyc(TK);
		pulse(5'h10);
		cyc(TK + 4);
		chk("relay_abort", relay_out, 0);
		pulse(5'h04);
		cyc(2 * TK - 4);
		chk("relay_early", relay_out, 0);
		cyc(8);
		chk("relay_expiry", relay_out, 1);
		bus(1'b0, 32'hc, 32'h0);
		chk("status_ready", q, 32'h0000000f);
		chk("hresp", hresp, 32'h0);
		for (i = 0; i < 6; i++) begin
			bus(1'b1, 32'h4, {6'h00, 10'h1f4, 5'h00, 3'(i), 8'(i % 2)});
			cyc(2);
			chk("kick", scfg.kick_start, 32'(i == 2 || i == 3));
			chk("cur_ramp", scfg.cur_ramp, 32'(i == 4));
			chk("dual", scfg.dual_loop, 32'(i == 5));
			chk("cur_limit", scfg.cur_limit, 32'(i == 0 || i == 2));
			chk("volt_ramp", scfg.volt_ramp, 32'(i == 1 || i == 3));
			chk("cur_cap", scfg.cur_cap, i == 5 ? 32'h0 : (i % 2 == 0 ? 32'h1f4 : 32'h190));
			chk("limit_on", scfg.limit_applies, 32'(i % 2 == 0 && i < 5));
			chk("free_stop", scfg.free_stop, 32'(i % 2 == 0));
		end
		bus(1'b1, 32'h4, 32'h01f50002);
		bus(1'b0, 32'h4, 32'h0);
		chk("limit_keep", q, 32'h01f40002);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, 32'h8, {16'h0000, 8'h32, 5'h00, 3'(i)});
			cyc(2);
			chk("trip3", pcfg.trip3_ds, t3[i]);
			chk("trip5", pcfg.trip5_ds, t5[i]);
			chk("trip4", pcfg.trip4_ds, t4[i]);
			chk("start_oc", pcfg.start_oc_s, oc[i]);
			chk("strict", pcfg.strict_start, 32'(i == 4));
			chk("prot_en", pcfg.prot_en, i == 0 ? msr_pkg::PE_PRIMARY : msr_pkg::PE_ALL);
		end
		chk("scaled", scfg.cur_cap_scaled, 32'd250);
		bus(1'b1, 32'h8, 32'h3205);
		bus(1'b0, 32'h8, 32'h0);
		chk("level_keep", q, 32'h3204);
		bus(1'b1, 32'h4, 32'h01180602);
		cyc(2);
		chk("monitor", scfg.monitor, 1);
		for (i = 0; i < 3; i++) begin
			stat <= {1'b1, 10'h000, 3'(3'h4 >> i)};
			@(posedge hclk);
			stat <= 14'h2000;
			cyc(1);
			chk("fault_open", fco, 1);
			chk("fault_code", fdisp, 32'h20 + i);
			pulse(5'h10);
			cyc(1);
			chk("fault_clear", fco, 0);
		end
		results();
	end
endmodule
